// File: verilog/cdrlc_pkg.sv
/*
  Shared constants, types and helpers of the CDR lock and calibration
  control block. Assumes a 100 MHz system clock; all pins are taken as
  synchronous to it.
*/
package cdrlc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 100;
  localparam int PD_MIN_NS = 1000;
  localparam int PD_MIN_CYC = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_TIME_US = 1500;
  localparam int CAL_CYC = CAL_TIME_US * CLK_MHZ;
  localparam int RETRY_US = 60;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int LOL_PPM = 600;
  localparam int LOCK_PPM = 300;

  // ==========================================================
  // Widths and limits
  // ==========================================================
  localparam int ACC_W = 24;
  localparam int CNT_W = 21;
  localparam int TB_LOG2 = 10;
  localparam logic [7:0] PD_LIM = 8'(PD_MIN_CYC);
  localparam logic [7:0] REF_LIM = 8'h40;
  localparam logic [8:0] DATA_LIM = 9'h100;
  localparam logic [3:0] KP_BASE = 4'h8;
  localparam logic [3:0] KI_BASE = 4'h2;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_PWRDN = 4'h1,
    ST_WREF = 4'h2,
    ST_CAL = 4'h4,
    ST_RUN = 4'h8
  } cdrlc_state_type;

  typedef enum logic [1:0] {
    RATIO_16 = 2'h0,
    RATIO_32 = 2'h1,
    RATIO_128 = 2'h2
  } cdrlc_ratio_type;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam logic [31:0] REG_WORD = 32'h0000_0008;
  localparam logic [31:0] REG_REFCNT = 32'h0000_000C;
  localparam int CTRL_RETRY_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int STAT_LOL_BIT = 0;
  localparam int STAT_REF_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_DATA_BIT = 3;
  localparam int STAT_RATIO_LSB = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Oscillator-to-reference multiple
  function automatic int ratio_val(input cdrlc_ratio_type r);
    case (r)
      RATIO_16: ratio_val = 16;
      RATIO_32: ratio_val = 32;
      default: ratio_val = 128;
    endcase
  endfunction

  // Magnitude of a difference
  function automatic int abs_diff(input int a, input int b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // Edge-count tolerance for a ppm figure over a window
  function automatic int ppm_count(input cdrlc_ratio_type r, input int ppm,
                                   input int win_log2);
    ppm_count = ratio_val(r) * (1 << win_log2) * ppm / 1000000;
  endfunction

endpackage

// File: verilog/cdrlc_mon_if.sv
/*
  Bundle between the core, the reference monitor and the lock detector.
  Assumes all three run on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface cdrlc_mon_if import cdrlc_pkg::*; ();
  logic ref_edge;
  logic ref_present;
  cdrlc_ratio_type ratio;
  logic [TB_LOG2:0] ref_cnt;
  logic nco_edge;
  logic run;
  logic locked;
  modport mon (output ref_edge, ref_present, ratio, ref_cnt);
  modport lock (input ref_edge, nco_edge, ratio, run, output locked);
  modport core (input ref_edge, ref_present, ratio, ref_cnt, locked,
                output nco_edge, run);
endinterface
`default_nettype wire

// File: verilog/cdrlc_ref_monitor.sv
/*
  Reference activity detector and automatic ratio selection.
  Assumes the reference level is synchronous to the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cdrlc_ref_monitor import cdrlc_pkg::*; #(
  parameter int NOM_OSC_CNT = 4096
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reference_clock_i,
  cdrlc_mon_if.mon mon
);
  typedef struct packed {
    logic ref_prev;
    logic [7:0] idle;
    logic present;
    logic [TB_LOG2-1:0] tb;
    logic [TB_LOG2:0] edges;
    logic [TB_LOG2:0] ref_cnt;
    cdrlc_ratio_type ratio;
  } cdrlc_mon_type;

  cdrlc_mon_type q, n;
  logic [TB_LOG2:0] fin;
  int e16, e32, e128;

  // ==========================================================
  // Edge detect and window
  // ==========================================================
  assign mon.ref_edge = reference_clock_i & ~q.ref_prev;
  assign fin = q.edges + {{TB_LOG2{1'b0}}, mon.ref_edge};

  // Next-state logic
  always_comb begin
    n = q;
    e16 = abs_diff(int'(fin) * 16, NOM_OSC_CNT);
    e32 = abs_diff(int'(fin) * 32, NOM_OSC_CNT);
    e128 = abs_diff(int'(fin) * 128, NOM_OSC_CNT);
    n.ref_prev = reference_clock_i;
    if (mon.ref_edge) begin
      n.idle = 8'h00;
      n.present = 1'b1;
    end else if (q.idle < REF_LIM - 8'h01) begin
      n.idle = q.idle + 8'h01;
    end else begin
      n.present = 1'b0;
    end
    n.tb = q.tb + {{(TB_LOG2-1){1'b0}}, 1'b1};
    n.edges = fin;
    if (&q.tb) begin
      n.edges = '0;
      n.ref_cnt = fin;
      if (e16 <= e32 && e16 <= e128) begin
        n.ratio = RATIO_16;
      end else if (e32 <= e128) begin
        n.ratio = RATIO_32;
      end else begin
        n.ratio = RATIO_128;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{ratio: RATIO_16, default: '0};
    end else begin
      q <= n;
    end
  end

  assign mon.ref_present = q.present;
  assign mon.ratio = q.ratio;
  assign mon.ref_cnt = q.ref_cnt;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  ref_seen_a: assert property (mon.ref_edge |=> mon.ref_present)
    else $error("reference edge not seen as present");
  ref_lost_a: assert property ((q.idle == REF_LIM - 8'h01 && !mon.ref_edge)
    |=> !mon.ref_present)
    else $error("silent reference still present");
  ratio_win_a: assert property ((&q.tb) |=> mon.ref_cnt == $past(fin))
    else $error("reference count not latched");
endmodule
`default_nettype wire

// File: verilog/cdrlc_lock_detect.sv
/*
  Frequency lock detector with hysteresis. Counts oscillator edges over
  a window of reference edges. Assumes one system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cdrlc_lock_detect import cdrlc_pkg::*; #(
  parameter int WIN_LOG2 = 12
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  cdrlc_mon_if.lock mon
);
  typedef struct packed {
    logic [WIN_LOG2-1:0] win;
    logic [CNT_W-1:0] osc;
    logic locked;
  } cdrlc_lock_type;

  cdrlc_lock_type q, n;
  logic win_end;
  logic [CNT_W-1:0] osc_fin;
  int diff, lol_th, lock_th;

  assign win_end = mon.ref_edge & (&q.win);
  assign osc_fin = q.osc + {{(CNT_W-1){1'b0}}, mon.nco_edge};

  // ==========================================================
  // Window compare
  // ==========================================================
  always_comb begin
    n = q;
    diff = abs_diff(int'(osc_fin), ratio_val(mon.ratio) << WIN_LOG2);
    lol_th = ppm_count(mon.ratio, LOL_PPM, WIN_LOG2);
    lock_th = ppm_count(mon.ratio, LOCK_PPM, WIN_LOG2);
    n.osc = osc_fin;
    if (mon.ref_edge) begin
      n.win = q.win + {{(WIN_LOG2-1){1'b0}}, 1'b1};
    end
    if (win_end) begin
      n.osc = '0;
      if (q.locked && diff > lol_th) begin
        n.locked = 1'b0;
      end
      if (!q.locked && diff <= lock_th) begin
        n.locked = 1'b1;
      end
    end
    if (!mon.run) begin
      n = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign mon.locked = q.locked;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  lock_drop_a: assert property ((mon.run && win_end && q.locked
    && diff > lol_th) |=> !mon.locked)
    else $error("lock kept beyond loss limit");
  lock_gain_a: assert property ((mon.run && win_end && !q.locked
    && diff <= lock_th) |=> mon.locked)
    else $error("lock not declared inside limit");
endmodule
`default_nettype wire

// File: verilog/cdrlc_top.sv
/*
  CDR lock and calibration control: powerdown and calibration sequence,
  digital loop filter steering a numeric oscillator, retiming, lock
  alarm, and an AHB-Lite register slave. Assumes every input is
  synchronous to clk_sys_i and a single AHB-Lite master.
*/
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
// Functional notes
// - A falling powerdown input with reference present starts a calibration; the code skips it after a pulse under PD_LIM cycles.
// - Alarm stays high while the reference shows no activity.
// - Ratio 16, 32 or 128 is chosen from the reference alone.
// - Divided oscillator is compared with the reference; deviation raises alarm.
// - Out of lock, acquisition is retried periodically; alarm may toggle.
// - Lock may persist after data loss; only frequency is judged.
// - Alarm is low while powerdown is held.
// - Powerdown disables the data and clock output drivers.
// - Release resets logic, recalibrates, then locks to data; the code goes straight to run after a pulse under PD_LIM cycles.
// - Data is retimed by the recovered clock; both leave together.
// - A digital filter turns phase error into the oscillator word.
// - Loss of lock is declared near 600 ppm deviation.
// - Lock is declared near 300 ppm, giving hysteresis.
// - Lock follows about 1.5 ms after release, 60 us after data.
// - Without data the output clock follows the reference.
`timescale 1ns/10ps
`default_nettype none
module cdrlc_top import cdrlc_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYC,
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int NOM_OSC_CNT = 4096,
  parameter int WIN_LOG2 = 12
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic powerdown_calibrate_i,
  input wire logic reference_clock_i,
  input wire logic din_i,
  output logic retimed_data_o,
  output logic recovered_clock_o,
  output logic out_drv_en_o,
  output logic lock_loss_alarm_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);
  localparam int MSB = ACC_W - 1;

  typedef struct packed {
    cdrlc_state_type st;
    logic pd;
    logic [7:0] pd_cnt;
    logic [CNT_W-1:0] tmr;
    logic din;
    logic ref_l;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] integ;
    logic [ACC_W-1:0] ctrl;
    logic [8:0] didle;
    logic [3:0] kp_sh;
    logic [3:0] ki_sh;
    logic rdata;
    logic rclk;
    logic drv_en;
    logic lock_loss_alarm;
    logic [1:0] ctrl_reg;
    logic ah_wr;
    logic [31:0] ah_addr;
    logic [31:0] hrdata;
  } cdrlc_core_type;

  // Pin copy starts high so reset never drops out of powerdown by itself
  localparam cdrlc_core_type CORE_RST = '{st: ST_PWRDN, ctrl_reg: CTRL_RST,
                                          kp_sh: KP_BASE, ki_sh: KI_BASE,
                                          pd: 1'b1, didle: DATA_LIM,
                                          default: '0};

  cdrlc_core_type q, n;
  cdrlc_mon_if mon ();

  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] center;
  logic [ACC_W-1:0] step_p;
  logic [ACC_W-1:0] step_i;
  logic dedge;
  logic data_present;
  logic nco_rise;
  logic [1:0] ctrl_now;
  logic [31:0] status;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Oscillator word that centres on ratio times the reference
  function automatic logic [ACC_W-1:0] center_word(
    input cdrlc_ratio_type r, input logic [TB_LOG2:0] cnt);
    logic [31:0] w;
    w = (32'(ratio_val(r)) * 32'(cnt)) << (ACC_W - TB_LOG2);
    if (w > 32'((1 << MSB) - 1)) begin
      w = 32'((1 << MSB) - 1);
    end
    center_word = w[ACC_W-1:0];
  endfunction

  // ==========================================================
  // Submodules
  // ==========================================================
  cdrlc_ref_monitor #(
    .NOM_OSC_CNT(NOM_OSC_CNT)
  ) u_ref_mon (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .reference_clock_i(reference_clock_i),
    .mon(mon.mon)
  );

  cdrlc_lock_detect #(
    .WIN_LOG2(WIN_LOG2)
  ) u_lock (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .mon(mon.lock)
  );

  // ==========================================================
  // Datapath terms
  // ==========================================================
  // Oscillator phase, loop steps and data activity
  assign acc_sum = q.acc + q.ctrl;
  assign center = center_word(mon.ratio, mon.ref_cnt);
  assign step_p = ACC_W'(1) << q.kp_sh;
  assign step_i = ACC_W'(1) << q.ki_sh;
  assign dedge = din_i ^ q.din;
  assign data_present = q.didle < DATA_LIM;
  assign nco_rise = ~q.acc[MSB] & acc_sum[MSB]
                    & (q.st == ST_RUN || q.st == ST_CAL);
  assign mon.nco_edge = nco_rise;
  assign mon.run = (q.st == ST_RUN);
  assign ctrl_now = (q.ah_wr && q.ah_addr == REG_CTRL)
                    ? hwdata_i[1:0] : q.ctrl_reg;

  // Status word
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_LOL_BIT] = q.lock_loss_alarm;
    status[STAT_REF_BIT] = mon.ref_present;
    status[STAT_LOCK_BIT] = mon.locked;
    status[STAT_DATA_BIT] = data_present;
    status[STAT_RATIO_LSB +: 2] = mon.ratio;
    status[STAT_STATE_LSB +: 4] = q.st;
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    n = q;
    n.pd = powerdown_calibrate_i;
    n.din = din_i;
    n.ref_l = reference_clock_i;
    if (dedge) begin
      n.didle = 9'h000;
    end else if (data_present) begin
      n.didle = q.didle + 9'h001;
    end
    if (q.st == ST_RUN || q.st == ST_CAL) begin
      n.acc = acc_sum;
    end
    case (q.st)
      ST_PWRDN: begin
        n.acc = '0;
        n.tmr = '0;
        n.integ = center;
        n.ctrl = center;
        if (!q.pd) begin
          n.pd_cnt = 8'h00;
          if (q.pd_cnt < PD_LIM) begin
            n.st = ST_RUN;
          end else if (mon.ref_present) begin
            n.st = ST_CAL;
          end else begin
            n.st = ST_WREF;
          end
        end else if (q.pd_cnt < PD_LIM) begin
          n.pd_cnt = q.pd_cnt + 8'h01;
        end
      end
      ST_WREF: begin
        if (mon.ref_present) begin
          n.st = ST_CAL;
          n.tmr = '0;
        end
      end
      ST_CAL: begin
        n.integ = center;
        n.ctrl = center;
        n.kp_sh = KP_BASE + {2'h0, mon.ratio};
        n.ki_sh = KI_BASE + {2'h0, mon.ratio};
        if (q.tmr == CAL_LAST) begin
          n.st = ST_RUN;
          n.tmr = '0;
        end else begin
          n.tmr = q.tmr + CNT_W'(1);
        end
      end
      ST_RUN: begin
        n.ctrl = q.integ;
        if (dedge && !q.ctrl_reg[CTRL_HOLD_BIT]) begin
          if (q.acc[MSB]) begin
            n.integ = q.integ - step_i;
            n.ctrl = q.integ - step_i - step_p;
          end else begin
            n.integ = q.integ + step_i;
            n.ctrl = q.integ + step_i + step_p;
          end
        end
        if (mon.locked || !q.ctrl_reg[CTRL_RETRY_BIT]) begin
          n.tmr = '0;
        end else if (q.tmr == RETRY_LAST) begin
          n.tmr = '0;
          n.integ = center;
          n.ctrl = center;
        end else begin
          n.tmr = q.tmr + CNT_W'(1);
        end
      end
      default: begin
        n.st = ST_PWRDN;
      end
    endcase
    // a held pin forces powerdown from any state
    if (q.pd) begin
      n.st = ST_PWRDN;
    end
    n.drv_en = (n.st != ST_PWRDN);
    if (n.st == ST_PWRDN) begin
      n.rclk = 1'b0;
      n.rdata = 1'b0;
    end else begin
      n.rclk = data_present ? acc_sum[MSB] : q.ref_l;
      // data taken on recovered rising edge
      if (nco_rise) begin
        n.rdata = q.din;
      end
    end
    n.lock_loss_alarm = (n.st != ST_PWRDN) && (!mon.ref_present || !mon.locked);
    // AHB-Lite address phase
    n.ah_wr = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      n.ah_addr = haddr_i;
      n.ah_wr = hwrite_i && hsize_i == HSIZE_WORD;
      case (haddr_i)
        REG_CTRL: n.hrdata = {30'h0, ctrl_now};
        REG_STATUS: n.hrdata = status;
        REG_WORD: n.hrdata = {{(32-ACC_W){1'b0}}, q.ctrl};
        REG_REFCNT: n.hrdata = {{(31-TB_LOG2){1'b0}}, mon.ref_cnt};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end
    // AHB-Lite data phase write
    if (q.ah_wr && q.ah_addr == REG_CTRL) begin
      n.ctrl_reg = hwdata_i[1:0];
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign retimed_data_o = q.rdata;
  assign recovered_clock_o = q.rclk;
  assign out_drv_en_o = q.drv_en;
  assign lock_loss_alarm_o = q.lock_loss_alarm;
  assign hrdata_o = q.hrdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  pd_lol_quiet_a: assert property (q.pd |=> !lock_loss_alarm_o)
    else $error("alarm raised during powerdown");
  pd_drv_off_a: assert property (q.pd |=> (!out_drv_en_o
    && !recovered_clock_o && !retimed_data_o))
    else $error("drivers active during powerdown");
  noref_alarm_a: assert property ((!q.pd && q.st != ST_PWRDN
    && !mon.ref_present) |=> lock_loss_alarm_o)
    else $error("alarm low with reference absent");
  cal_start_a: assert property ((q.st == ST_PWRDN && !q.pd
    && q.pd_cnt >= PD_LIM && mon.ref_present) |=> q.st == ST_CAL)
    else $error("calibration not started");
  release_exit_a: assert property ((q.st == ST_PWRDN && !q.pd)
    |=> (q.st != ST_PWRDN && q.acc == '0))
    else $error("release did not restart logic");
  retime_data_a: assert property ((nco_rise && !q.pd)
    |=> retimed_data_o == $past(q.din))
    else $error("retimed data mismatch");
  loop_steer_a: assert property ((q.st == ST_RUN && !q.pd && dedge
    && !q.ctrl_reg[CTRL_HOLD_BIT] && !(q.ctrl_reg[CTRL_RETRY_BIT]
    && !mon.locked && q.tmr == RETRY_LAST)) |=> q.ctrl != q.integ)
    else $error("phase error did not steer word");
  retry_load_a: assert property ((q.st == ST_RUN && !q.pd
    && !mon.locked && q.ctrl_reg[CTRL_RETRY_BIT] && q.tmr == RETRY_LAST)
    |=> (q.integ == $past(center) && q.tmr == '0))
    else $error("retry did not re-centre");
  cal_len_a: assert property (q.st == ST_CAL |-> q.tmr <= CAL_LAST)
    else $error("calibration overran");
  reference_clock_input_out_a: assert property ((q.st == ST_RUN && !q.pd && !data_present)
    |=> recovered_clock_o == $past(q.ref_l))
    else $error("clock not from reference");
  lol_track_a: assert property ((q.st == ST_RUN && !q.pd
    && !mon.locked) |=> lock_loss_alarm_o)
    else $error("alarm low while unlocked");
endmodule
`default_nettype wire

// File: test/cdrlc_line_src.sv
/*
  Far-side model: reference clock and serial data source.
  Assumes the bench clock; outputs change just after its rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cdrlc_line_src (
  input wire logic clk_i,
  input wire logic ref_en_i,
  input wire logic dat_en_i,
  input wire logic [7:0] half_i,
  output logic ref_o,
  output logic din_o
);
  logic [7:0] cnt;
  logic [15:0] lfsr;
  initial begin
    ref_o = 1'b0;
    din_o = 1'b0;
    cnt = 8'h00;
    lfsr = 16'hACE1;
  end
  // reference at line rate over ratio
  always @(posedge clk_i) begin
    cnt <= (cnt + 8'h01 >= half_i) ? 8'h00 : cnt + 8'h01;
    if (ref_en_i && cnt + 8'h01 >= half_i) ref_o <= ~ref_o;
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    if (dat_en_i) din_o <= lfsr[0];
  end
endmodule
`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench of the CDR control block.
  Assumes the line source model and short calibration counts.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import cdrlc_pkg::*;;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, pd = 1'b1;
  logic ref_en = 1'b1, dat_en = 1'b1, ref_w, din_w, hsel = 1'b0;
  logic hwrite = 1'b0, rdo, rco, den, alm, hro, hre, pro, prc;
  logic [7:0] half = 8'h02;
  logic [1:0] htrans = 2'h0, rh = 2'h0, dh = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd, q, v;
  logic [31:0] seed = 32'h4fdd;
  int bad_count = 0, checks_done = 0, m1, m2;
  localparam int NOM = 256;
  cdrlc_line_src cdrlc_line_src_inst (.clk_i(clk_sys_i), .ref_en_i(ref_en),
    .dat_en_i(dat_en), .half_i(half), .ref_o(ref_w), .din_o(din_w));
  cdrlc_top #(.CAL_CYCLES(200), .RETRY_CYCLES(100), .WIN_LOG2(6),
    .NOM_OSC_CNT(NOM))
    cdrlc_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .powerdown_calibrate_i(pd), .reference_clock_i(ref_w), .din_i(din_w),
    .retimed_data_o(rdo), .recovered_clock_o(rco), .out_drv_en_o(den),
    .lock_loss_alarm_o(alm), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hro), .hrdata_o(hrd),
    .hreadyout_o(hro), .hresp_o(hre));
  // ==========================================
  // Clock, history and helpers
  // ==========================================
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    rh <= {rh[0], ref_w};
    dh <= {dh[0], din_w};
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected ratio code: product nearest the nominal count
  function automatic int exp_ratio(input int h);
    int rc, best, r[3];
    r = '{16, 32, 128};
    rc = 1024 / (2 * h);
    best = 0;
    for (int i = 1; i < 3; i++) begin
      if (abs_diff(r[i] * rc, NOM) < abs_diff(r[best] * rc, NOM)) best = i;
    end
    return best;
  endfunction
  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Bounded wait for hready
  task wrdy();
    int n;
    n = 0;
    do begin
      wait_n(1);
      n++;
    end while (hro !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // One AHB-Lite single transfer, read data into q
  task ahb(input logic w, input logic [31:0] a, d, input logic [2:0] s);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    q = hrd;
  endtask
  task st(input logic [3:0] e);
    ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
    chk(32'(q[11:8]), 32'(e));
  endtask
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    wait_n(20);
    sys_rst_i <= 1'b0;
    wait_n(2);
    ahb(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
    chk(q, 32'(CTRL_RST));
    st(4'h1);
    chk(32'({den, rco, rdo}), 32'h0);
    chk(32'(alm), 32'h0);
    wait_n(150);
    pd <= 1'b0;
    wait_n(3);
    st(4'h4);
    chk(32'(den), 32'h1);
    wait_n(220);
    st(4'h8);
    $display("test calibration done");
    for (int i = 0; i < 3; i++) begin
      half <= 8'(i == 0 ? 200 : 128 >> i);
      wait_n(3000);
      ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
      chk(32'(q[5:4]), 32'(exp_ratio(int'(half))));
    end
    $display("test ratio done");
    // frozen loop stays locked and retimes data on rising clock edges
    ahb(1'b1, REG_CTRL, 32'h3, HSIZE_WORD);
    wait_n(12300);
    ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
    chk(32'({q[2], q[0], alm}), 32'h4);
    m1 = 0;
    pro = rdo;
    prc = rco;
    repeat (200) begin
      wait_n(1);
      if (rdo !== pro) begin
        m1++;
        chk(32'({rco, prc, rdo}), 32'({2'h2, dh[1]}));
      end
      pro = rdo;
      prc = rco;
    end
    chk(32'(m1 > 0), 32'h1);
    $display("test lock done");
    ref_en <= 1'b0;
    wait_n(100);
    chk(32'(alm), 32'h1);
    ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
    chk(32'(q[1]), 32'h0);
    ref_en <= 1'b1;
    wait_n(100);
    ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
    chk(32'(q[1]), 32'h1);
    dat_en <= 1'b0;
    wait_n(300);
    m1 = 0;
    m2 = 0;
    repeat (60) begin
      wait_n(1);
      m1 += int'(rco === rh[0]);
      m2 += int'(rco === rh[1]);
    end
    chk(32'(m1 == 60 || m2 == 60), 32'h1);
    dat_en <= 1'b1;
    $display("test reference done");
    pd <= 1'b1;
    wait_n(20);
    chk(32'({den, rco, rdo}), 32'h0);
    chk(32'(alm), 32'h0);
    pd <= 1'b0;
    wait_n(4);
    st(4'h8);
    ref_en <= 1'b0;
    pd <= 1'b1;
    wait_n(120);
    pd <= 1'b0;
    wait_n(4);
    st(4'h2);
    ref_en <= 1'b1;
    wait_n(80);
    st(4'h4);
    $display("test powerdown done");
    repeat (3) begin
      v = xs();
      ahb(1'b1, REG_CTRL, v, HSIZE_WORD);
      ahb(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
      chk(q, {30'h0, v[1:0]});
    end
    ahb(1'b1, REG_CTRL, 32'(CTRL_RST), HSIZE_WORD);
    ahb(1'b1, REG_CTRL, 32'h0, 3'h1);
    ahb(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
    chk(q, 32'(CTRL_RST));
    ahb(1'b0, 32'h0000_0010, 32'h0, HSIZE_WORD);
    chk(q, 32'h0);
    $display("test registers done");
    wrap_up();
  end
endmodule
`default_nettype wire
